/* rtl/sarcs_regs.svh */
// Constants of the successive-approximation conversion sequencer
`ifndef SARCS_REGS_SVH
`define SARCS_REGS_SVH
`define SARCS_NBITS       16
`define SARCS_MSB_IDX     4'hF
`define SARCS_CODE_POSMAX 16'h7FFF
`define SARCS_CODE_NEGMAX 16'h8000
`define SARCS_CODE_ZERO   16'h0000
`define SARCS_TRIAL_INIT  16'h8000
`define SARCS_OPEN_CYC    2
`define SARCS_DISC_CYC    2
`define SARCS_TRIAL_CYC   4
`define SARCS_CNT_W       4
`endif

/* rtl/sarcs_pkg.sv */
// Types of the successive-approximation conversion sequencer
package sarcs_pkg;
  typedef enum logic [2:0] {
    SARCS_ACQ   = 3'b000,
    SARCS_OPEN  = 3'b001,
    SARCS_DISC  = 3'b010,
    SARCS_TRIAL = 3'b011,
    SARCS_LATCH = 3'b100
  } sarcs_state_t;

  typedef struct packed {
    logic pos_ground_switch;
    logic neg_ground_switch;
    logic array_to_inputs;
    logic array_to_ground;
    logic powered_down;
  } sarcs_switch_t;

  typedef struct packed {
    logic [15:0] code;
    logic        done;
    logic        busy;
  } sarcs_result_t;
endpackage : sarcs_pkg

/* rtl/sarcs_sequencer.sv */
// Control sequencer of a 16-bit charge-redistribution successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "sarcs_regs.svh"

// Overview of operation
// - During acquisition both grounding switches are closed and the arrays follow the analog inputs.
// - A rising edge on convert_start during acquisition ends acquisition and starts a conversion.
// - Conversion first opens both grounding switches and only then moves the arrays from inputs to ground.
// - Sixteen bit trials run from the most significant element down to the one weighted 1/65536.
// - When the search ends the block returns to acquisition, forms the code and pulses done.
// - Conversion is timed by the core clock alone and needs no serial clock.
// - The code is 16-bit two's complement with midscale at zero.
// - Over-range gives 7FFF and under-range gives 8000.
// - Conversions may repeat at full rate and the analog side is powered down between them.
// - Each result belongs to the conversion just completed, with no pipeline delay.
// - A started conversion runs to completion whatever convert_start does.
module sarcs_sequencer #(
  parameter int OPEN_CYC  = `SARCS_OPEN_CYC,
  parameter int DISC_CYC  = `SARCS_DISC_CYC,
  parameter int TRIAL_CYC = `SARCS_TRIAL_CYC
) (
  input  wire logic                    core_clk,      // Core clock, 200 MHz
  input  wire logic                    reset,         // Synchronous reset, active high
  input  wire logic                    clk_en,        // Freezes all state while low
  input  wire logic                    convert_start, // Convert pin, asynchronous
  input  wire logic                    comp_high,     // Comparator output, asynchronous
  input  wire logic                    over_range,    // Input above positive full scale
  input  wire logic                    under_range,   // Input below negative full scale
  output logic                         pos_ground_switch, // Positive grounding switch closed
  output logic                         neg_ground_switch, // Negative grounding switch closed
  output logic                         array_to_inputs,   // Arrays tied to analog inputs
  output logic                         array_to_ground,   // Arrays tied to ground
  output logic                         powered_down,      // Analog core powered down
  output logic [`SARCS_NBITS-1:0]      trial_bits,        // Array element drive, 1 = REF
  output sarcs_pkg::sarcs_result_t     result             // Code, done pulse and busy
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] cnv_sync;
  logic [1:0] cmp_sync;
  logic [1:0] ovr_sync;
  logic [1:0] und_sync;
  logic       cnv_prev;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnv_sync <= 2'h0;
      cmp_sync <= 2'h0;
      ovr_sync <= 2'h0;
      und_sync <= 2'h0;
      cnv_prev <= 1'b0;
    end else if (clk_en) begin
      cnv_sync <= {cnv_sync[0], convert_start};
      cmp_sync <= {cmp_sync[0], comp_high};
      ovr_sync <= {ovr_sync[0], over_range};
      und_sync <= {und_sync[0], under_range};
      cnv_prev <= cnv_sync[1];
    end
  end

  logic cnv_rise;
  assign cnv_rise = cnv_sync[1] & ~cnv_prev;

  // ****************************************
  // Sequencer
  // ****************************************
  sarcs_pkg::sarcs_state_t state;
  logic [`SARCS_CNT_W-1:0] bit_idx;
  logic [7:0]              phase_cnt;
  logic [`SARCS_NBITS-1:0] sar;
  logic                    phase_end;

  always_comb begin
    phase_end = 1'b0;
    case (state)
      sarcs_pkg::SARCS_OPEN:  phase_end = (phase_cnt == 8'(OPEN_CYC - 1));
      sarcs_pkg::SARCS_DISC:  phase_end = (phase_cnt == 8'(DISC_CYC - 1));
      sarcs_pkg::SARCS_TRIAL: phase_end = (phase_cnt == 8'(TRIAL_CYC - 1));
      default:                phase_end = 1'b1;
    endcase
  end

  // Only the core clock advances the search; no serial clock is involved
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= sarcs_pkg::SARCS_ACQ;
    end else if (clk_en) begin
      case (state)
        sarcs_pkg::SARCS_ACQ: begin
          if (cnv_rise) begin
            state <= sarcs_pkg::SARCS_OPEN;
          end
        end
        sarcs_pkg::SARCS_OPEN: begin
          if (phase_end) begin
            state <= sarcs_pkg::SARCS_DISC;
          end
        end
        sarcs_pkg::SARCS_DISC: begin
          if (phase_end) begin
            state <= sarcs_pkg::SARCS_TRIAL;
          end
        end
        sarcs_pkg::SARCS_TRIAL: begin
          if (phase_end && bit_idx == 4'h0) begin
            state <= sarcs_pkg::SARCS_LATCH;
          end
        end
        sarcs_pkg::SARCS_LATCH: begin
          state <= sarcs_pkg::SARCS_ACQ;
        end
        default: begin
          state <= sarcs_pkg::SARCS_ACQ;
        end
      endcase
    end
  end

  // Fixed phase lengths, convert_start ignored once started
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phase_cnt <= 8'h00;
    end else if (clk_en) begin
      if (state == sarcs_pkg::SARCS_ACQ || phase_end) begin
        phase_cnt <= 8'h00;
      end else begin
        phase_cnt <= phase_cnt + 8'h01;
      end
    end
  end

  // Trial bit set, then kept or dropped on the comparator at phase end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bit_idx <= `SARCS_MSB_IDX;
      sar     <= `SARCS_CODE_ZERO;
    end else if (clk_en) begin
      if (state == sarcs_pkg::SARCS_DISC && phase_end) begin
        bit_idx <= `SARCS_MSB_IDX;
        sar     <= `SARCS_TRIAL_INIT;
      end else if (state == sarcs_pkg::SARCS_TRIAL && phase_end) begin
        if (cmp_sync[1]) begin
          sar[bit_idx] <= 1'b0;
        end
        if (bit_idx != 4'h0) begin
          sar[bit_idx - 4'h1] <= 1'b1;
          bit_idx             <= bit_idx - 4'h1;
        end
      end
    end
  end

  // ****************************************
  // Result
  // ****************************************
  logic [`SARCS_NBITS-1:0] code;
  logic                    done;

  // Offset binary to two's complement by MSB flip, clamped on range flags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      code <= `SARCS_CODE_ZERO;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (state == sarcs_pkg::SARCS_LATCH) begin
        done <= 1'b1;
        if (ovr_sync[1]) begin
          code <= `SARCS_CODE_POSMAX;
        end else if (und_sync[1]) begin
          code <= `SARCS_CODE_NEGMAX;
        end else begin
          code <= {~sar[15], sar[14:0]};
        end
      end
    end
  end

  // ****************************************
  // Switch and power control
  // ****************************************
  logic acq;
  assign acq               = (state == sarcs_pkg::SARCS_ACQ);
  assign pos_ground_switch = acq;
  assign neg_ground_switch = acq;
  assign array_to_inputs   = acq || state == sarcs_pkg::SARCS_OPEN;
  assign array_to_ground   = !array_to_inputs;
  assign powered_down      = acq;
  assign trial_bits        = (state == sarcs_pkg::SARCS_TRIAL) ? sar : `SARCS_CODE_ZERO;
  assign result            = '{code: code, done: done, busy: !acq};

  // ****************************************
  // Checks
  // ****************************************
  a_acq_grounded: assert property (@(posedge core_clk) disable iff (reset)
    acq |-> pos_ground_switch && neg_ground_switch && array_to_inputs && !array_to_ground
            && trial_bits == `SARCS_CODE_ZERO)
    else $error("grounding switches open in acquisition");
  a_start_edge: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && acq && cnv_rise) |=> state == sarcs_pkg::SARCS_OPEN)
    else $error("convert edge did not start conversion");
  a_open_first: assert property (@(posedge core_clk) disable iff (reset)
    $fell(pos_ground_switch) |-> array_to_inputs)
    else $error("arrays left inputs before switches opened");
  a_done_pulse: assert property (@(posedge core_clk) disable iff (reset)
    (done && $past(clk_en)) |-> acq && $past(state) == sarcs_pkg::SARCS_LATCH)
    else $error("done not tied to latch");
  a_clamp_pos: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == sarcs_pkg::SARCS_LATCH && ovr_sync[1]) |=> code == `SARCS_CODE_POSMAX)
    else $error("over-range not clamped");
  a_clamp_neg: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == sarcs_pkg::SARCS_LATCH && !ovr_sync[1] && und_sync[1])
    |=> code == `SARCS_CODE_NEGMAX)
    else $error("under-range not clamped");
  a_code_map: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == sarcs_pkg::SARCS_LATCH && !ovr_sync[1] && !und_sync[1])
    |=> code == {~$past(sar[15]), $past(sar[14:0])})
    else $error("code not two's complement of search");
  a_fixed_len: assert property (@(posedge core_clk) disable iff (reset)
    (state == sarcs_pkg::SARCS_DISC && phase_end && clk_en) ##1 clk_en [*8]
    |-> state == sarcs_pkg::SARCS_TRIAL && bit_idx != `SARCS_MSB_IDX)
    else $error("trial phase length wrong");
  a_power_down: assert property (@(posedge core_clk) disable iff (reset)
    $rose(powered_down) |-> $past(state) == sarcs_pkg::SARCS_LATCH)
    else $error("power-down not at end of conversion");

endmodule : sarcs_sequencer
`default_nettype wire

/* sim/sarcs_comp_model.sv */
// Comparator model facing the sequencer's capacitor arrays
`timescale 1ns/1ps
`default_nettype none

module sarcs_comp_model (
  input  wire logic        core_clk,   // Core clock, unused by the ideal comparator
  input  wire logic [15:0] trial_bits, // Array element drive from the sequencer
  input  wire logic [15:0] level,      // Held sample, two's complement
  output logic             comp_high   // High while the trial word is above the sample
);
  // Sample moved to offset binary so that the MSB-first search lands on it
  always_comb begin
    comp_high = trial_bits > (level ^ 16'h8000);
  end
endmodule : sarcs_comp_model

`default_nettype wire

/* sim/testbench.sv */
// Self-checking testbench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int OPEN_CYC  = 2;
  localparam int DISC_CYC  = 2;
  localparam int TRIAL_CYC = 4;
  localparam int NCYC      = OPEN_CYC + DISC_CYC + 16 * TRIAL_CYC + 1;

  logic                     core_clk, reset, clk_en, convert_start, comp_high, over_range, under_range;
  logic                     pos_ground_switch, neg_ground_switch, array_to_inputs, array_to_ground, powered_down;
  logic [15:0]              trial_bits;
  logic [15:0]              level;
  sarcs_pkg::sarcs_result_t result;
  int                       err_count = 0;
  int                       n_compared = 0;
  logic [15:0]              vals [7] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h0001, 16'h8001, 16'h5A5A};

  sarcs_sequencer #(.OPEN_CYC(OPEN_CYC), .DISC_CYC(DISC_CYC), .TRIAL_CYC(TRIAL_CYC)) uut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .convert_start(convert_start),
    .comp_high(comp_high), .over_range(over_range), .under_range(under_range),
    .pos_ground_switch(pos_ground_switch), .neg_ground_switch(neg_ground_switch),
    .array_to_inputs(array_to_inputs), .array_to_ground(array_to_ground),
    .powered_down(powered_down), .trial_bits(trial_bits), .result(result));

  sarcs_comp_model comp (.core_clk(core_clk), .trial_bits(trial_bits), .level(level), .comp_high(comp_high));

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      $display("ERROR %0t %s", $time, msg);
      err_count++;
    end
  endtask : chk

  // One conversion: optional clamp inputs, pin glitches mid-run, clock-enable stall
  task automatic conv(input logic [15:0] v, input logic ov, input logic un, input logic glitch, input int stall);
    int          nb;
    logic        seen_tb;
    logic [15:0] expv;
    nb = 0;
    seen_tb = 1'b0;
    expv = ov ? 16'h7FFF : (un ? 16'h8000 : v);
    level = v;
    over_range = ov;
    under_range = un;
    convert_start = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk);
      #1;
      if (result.done === 1'b1) break;
      if (result.busy === 1'b1) nb++;
      if (nb == 1) begin
        chk(array_to_ground === 1'b0 && pos_ground_switch === 1'b0 && neg_ground_switch === 1'b0,
            "switch order");
      end
      if (nb == OPEN_CYC + 1) begin
        chk(array_to_ground === 1'b1 && array_to_inputs === 1'b0 && pos_ground_switch === 1'b0,
            "arrays not grounded after switches opened");
      end
      if (!seen_tb && trial_bits !== 16'h0000) begin
        seen_tb = 1'b1;
        chk(trial_bits === 16'h8000, "first trial is not the top element");
      end
      if (i == 8) convert_start = 1'b0;
      if (glitch && (i == 12 || i == 30)) convert_start = ~convert_start;
      clk_en = !(i >= 20 && i < 20 + stall);
    end
    if (result.done !== 1'b1) begin
      chk(1'b0, "no done within bound");
      close_out();
    end else begin
      chk(result.code === expv, "wrong code");
      chk(nb == NCYC + stall, "conversion length");
      chk(pos_ground_switch === 1'b1 && neg_ground_switch === 1'b1 && array_to_inputs === 1'b1,
          "not back in acquisition");
      chk(powered_down === 1'b1 && array_to_ground === 1'b0 && result.busy === 1'b0,
          "not powered down");
      repeat (6) @(posedge core_clk);
      #1;
      chk(result.done === 1'b0 && result.busy === 1'b0 && result.code === expv,
          "restart or code lost");
    end
  endtask : conv

  // Back-to-back conversions of distinct values
  task automatic run_codes();
    foreach (vals[k]) conv(vals[k], 1'b0, 1'b0, 1'b0, 0);
  endtask : run_codes

  // Over-range, under-range and both at once
  task automatic run_clamps();
    conv(16'h1234, 1'b1, 1'b0, 1'b0, 0);
    conv(16'h1234, 1'b0, 1'b1, 1'b0, 0);
    conv(16'h1234, 1'b1, 1'b1, 1'b0, 0);
  endtask : run_clamps

  // Convert pin toggled while the search runs
  task automatic run_glitch();
    conv(16'hC3A5, 1'b0, 1'b0, 1'b1, 0);
  endtask : run_glitch

  // Clock enable held low in the middle of the search
  task automatic run_stall();
    conv(16'h2F0D, 1'b0, 1'b0, 1'b0, 9);
  endtask : run_stall

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    convert_start = 1'b0;
    over_range = 1'b0;
    under_range = 1'b0;
    level = 16'h0000;
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    chk(result.busy === 1'b0 && result.code === 16'h0000 && pos_ground_switch === 1'b1, "reset state");
    chk(array_to_inputs === 1'b1 && neg_ground_switch === 1'b1 && array_to_ground === 1'b0, "acquire");
    run_codes();
    run_clamps();
    run_glitch();
    run_stall();
    close_out();
  end
endmodule : testbench

`default_nettype wire
